// ===== dctg_counter.v
// Reloadable down-counter holding off one command class.
// Assumes a single clock and an asynchronous active-low reset.
`include "dctg_defines.vh"

module dctg_counter #(
	parameter WIDTH = 10
) (
	// Clock and reset
	input  wire             mclk,
	input  wire             resetn,
	// Control
	input  wire             load,
	input  wire [WIDTH-1:0] value,
	// Status
	output wire             busy
);
	reg  [WIDTH:0] cnt_ff;
	wire [WIDTH:0] nxt_cnt;

	// Value plus one cycles of hold-off after the load edge
	assign nxt_cnt = load ? {1'b0, value} + {{WIDTH{1'b0}}, 1'b1} :
		(cnt_ff != {(WIDTH+1){1'b0}}) ? cnt_ff - {{WIDTH{1'b0}}, 1'b1} : cnt_ff;
	assign busy = (cnt_ff != {(WIDTH+1){1'b0}});

	always @(posedge mclk or negedge resetn) begin
		if (!resetn)
			cnt_ff <= {(WIDTH+1){1'b0}};
		else
			cnt_ff <= nxt_cnt;
	end
endmodule

// ===== dctg_defines.vh
// Constants of the DDR3 command timing guard: offsets, fields, resets.
// Assumes inclusion by bare name from the design files of this block.
`ifndef DCTG_DEFINES_VH
`define DCTG_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define DCTG_OFS_ROW_TIMING_SECOND    8'h00
`define DCTG_OFS_POWER_EXIT_TIMING    8'h04
`define DCTG_OFS_REFRESH_CALIB_TIMING 8'h08
`define DCTG_OFS_GUARD_STATUS         8'h0C

// ****************************************
// Reset values and writable masks
// ****************************************
`define DCTG_RST_ROW2   32'h0000_1FFF
`define DCTG_MSK_ROW2   32'h0000_1FFF
`define DCTG_RST_PWR    32'hFFFF_FFFF
`define DCTG_MSK_PWR    32'hFFFF_FFFF
`define DCTG_RST_REF    32'hFFFF_3FFF
`define DCTG_MSK_REF    32'hFFFF_3FFF

// ****************************************
// Field positions (msb, lsb)
// ****************************************
`define DCTG_RTW_MSB    12
`define DCTG_RTW_LSB    10
`define DCTG_RP_MSB     9
`define DCTG_RP_LSB     5
`define DCTG_RCD_MSB    4
`define DCTG_RCD_LSB    0
`define DCTG_XP_MSB     31
`define DCTG_XP_LSB     28
`define DCTG_XSNR_MSB   27
`define DCTG_XSNR_LSB   18
`define DCTG_XSRD_MSB   17
`define DCTG_XSRD_LSB   8
`define DCTG_RTP_MSB    7
`define DCTG_RTP_LSB    4
`define DCTG_CKE_MSB    3
`define DCTG_CKE_LSB    0
`define DCTG_CSTA_MSB   31
`define DCTG_CSTA_LSB   28
`define DCTG_CKESR_MSB  27
`define DCTG_CKESR_LSB  24
`define DCTG_ZQCS_MSB   23
`define DCTG_ZQCS_LSB   16
`define DCTG_RFC_MSB    13
`define DCTG_RFC_LSB    4

// ****************************************
// Command encodings
// ****************************************
`define DCTG_CMD_NOP    3'h0
`define DCTG_CMD_ACT    3'h1
`define DCTG_CMD_RD     3'h2
`define DCTG_CMD_WR     3'h3
`define DCTG_CMD_PRE    3'h4
`define DCTG_CMD_REF    3'h5
`define DCTG_CMD_MRS    3'h6
`define DCTG_CMD_ZQCS   3'h7

`endif

// ===== dctg_guard.v
// DDR3 command timing guard: three timing registers over AXI4-Lite and
// hold-off counters that tell the scheduler which commands are legal.
// Assumes the scheduler only issues a command while its allow bit is high.
// Notes on behaviour
// RULE_01: read-to-write data gap is turnaround plus one
// RULE_02: precharge to refresh/activate waits period plus one
// RULE_03: activate to read/write waits delay plus one
// RULE_04: powerdown exit to non-read waits plus one; allow_rd_wr is not held by it, so writes are not held
// RULE_05: selfrefresh exit to non-DLL command waits
// RULE_06: selfrefresh exit to DLL command waits longer
// RULE_07: last read to precharge waits plus one
// RULE_08: clock-enable output held stable between transitions
// RULE_09: rank switch between same-direction data phases spaced
// RULE_10: selfrefresh residency minimum before exit allowed
// RULE_11: short calibration blocks next command
// RULE_12: refresh or mode load to refresh/activate waits
// RULE_13: software writes fifteen to row-active max field
// RULE_14: reserved bits read zero, writes ignored
// RULE_15: software derives turnaround from board delays
// RULE_16: each constraint a down-counter loaded on trigger
`include "dctg_defines.vh"

module dctg_guard (
	// Clock and reset
	input  wire        mclk,
	input  wire        resetn,
	// AXI4-Lite write address
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// AXI4-Lite write response
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// AXI4-Lite read data
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	// Scheduler command report
	input  wire [2:0]  cmd_issue,
	input  wire        cmd_rank,
	input  wire        rd_data_start,
	input  wire        wr_data_start,
	input  wire        data_rank,
	input  wire        cke_request,
	input  wire        selfrefresh_entered,
	// Scheduler permissions
	output wire        allow_act_ref,
	output wire        allow_rd_wr,
	output wire        allow_pre,
	output wire        allow_other,
	output wire        allow_dll_cmd,
	output wire        allow_rd_data,
	output wire        allow_wr_data,
	output wire        allow_sr_exit,
	// Memory pin
	output wire        memory_clock_enable_out
);
	// ****************************************
	// Registers and AXI4-Lite slave
	// ****************************************
	reg [31:0] row2_ff;
	reg [31:0] pwr_ff;
	reg [31:0] ref_ff;
	reg [7:0]  awaddr_ff;
	reg        aw_ok_ff;
	reg [31:0] wdata_ff;
	reg [3:0]  wstrb_ff;
	reg        w_ok_ff;
	reg        bvalid_ff;
	reg [1:0]  bresp_ff;
	reg        rvalid_ff;
	reg [31:0] rdata_ff;
	reg [1:0]  rresp_ff;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		input [31:0] mask;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge[i*8 +: 8] = data[i*8 +: 8];
			merge = merge & mask; // [RULE_14]
		end
	endfunction

	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `DCTG_OFS_ROW_TIMING_SECOND) || (a == `DCTG_OFS_POWER_EXIT_TIMING) ||
				(a == `DCTG_OFS_REFRESH_CALIB_TIMING) || (a == `DCTG_OFS_GUARD_STATUS);
		end
	endfunction

	wire do_write;
	wire [31:0] status_word;

	assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
	assign s_axi_wready  = !w_ok_ff && !bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign do_write      = aw_ok_ff && w_ok_ff && !bvalid_ff;

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			awaddr_ff <= 8'h00;
			aw_ok_ff  <= 1'b0;
			wdata_ff  <= 32'h0000_0000;
			wstrb_ff  <= 4'h0;
			w_ok_ff   <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= 2'h0;
			row2_ff   <= `DCTG_RST_ROW2;
			pwr_ff    <= `DCTG_RST_PWR;
			ref_ff    <= `DCTG_RST_REF;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_ff <= s_axi_awaddr;
				aw_ok_ff  <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
				w_ok_ff  <= 1'b1;
			end
			if (do_write) begin
				aw_ok_ff  <= 1'b0;
				w_ok_ff   <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff  <= mapped(awaddr_ff) ? 2'h0 : 2'h3;
				case (awaddr_ff)
				`DCTG_OFS_ROW_TIMING_SECOND:
					row2_ff <= merge(row2_ff, wdata_ff, wstrb_ff, `DCTG_MSK_ROW2);
				`DCTG_OFS_POWER_EXIT_TIMING:
					pwr_ff <= merge(pwr_ff, wdata_ff, wstrb_ff, `DCTG_MSK_PWR);
				`DCTG_OFS_REFRESH_CALIB_TIMING:
					ref_ff <= merge(ref_ff, wdata_ff, wstrb_ff, `DCTG_MSK_REF);
				default: begin
				end
				endcase
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= mapped(s_axi_araddr) ? 2'h0 : 2'h3;
			case (s_axi_araddr)
			`DCTG_OFS_ROW_TIMING_SECOND:    rdata_ff <= row2_ff;
			`DCTG_OFS_POWER_EXIT_TIMING:    rdata_ff <= pwr_ff;
			`DCTG_OFS_REFRESH_CALIB_TIMING: rdata_ff <= ref_ff;
			`DCTG_OFS_GUARD_STATUS:         rdata_ff <= status_word;
			default:                        rdata_ff <= 32'h0000_0000;
			endcase
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// ****************************************
	// Field extraction
	// ****************************************
	// Turnaround comes from board delays, not memory timing
	wire [2:0] read_write_turnaround     = row2_ff[`DCTG_RTW_MSB:`DCTG_RTW_LSB]; // [RULE_15]
	wire [4:0] precharge_period          = row2_ff[`DCTG_RP_MSB:`DCTG_RP_LSB];
	wire [4:0] row_to_column_delay       = row2_ff[`DCTG_RCD_MSB:`DCTG_RCD_LSB];
	wire [3:0] powerdown_exit_delay      = pwr_ff[`DCTG_XP_MSB:`DCTG_XP_LSB];
	wire [9:0] selfrefresh_exit_nodll    = pwr_ff[`DCTG_XSNR_MSB:`DCTG_XSNR_LSB];
	wire [9:0] selfrefresh_exit_dll      = pwr_ff[`DCTG_XSRD_MSB:`DCTG_XSRD_LSB];
	wire [3:0] read_to_precharge         = pwr_ff[`DCTG_RTP_MSB:`DCTG_RTP_LSB];
	wire [3:0] cke_min_hold              = pwr_ff[`DCTG_CKE_MSB:`DCTG_CKE_LSB];
	wire [3:0] rank_switch_gap           = ref_ff[`DCTG_CSTA_MSB:`DCTG_CSTA_LSB];
	wire [3:0] selfrefresh_min_residency = ref_ff[`DCTG_CKESR_MSB:`DCTG_CKESR_LSB];
	wire [7:0] short_calibration_time    = ref_ff[`DCTG_ZQCS_MSB:`DCTG_ZQCS_LSB];
	wire [9:0] refresh_cycle_time        = ref_ff[`DCTG_RFC_MSB:`DCTG_RFC_LSB];
	// Row-active max field kept as written; software must leave it at 0xF [RULE_13]

	// ****************************************
	// Trigger decode
	// ****************************************
	reg        cke_ff;
	reg        last_dir_wr_ff;
	reg        last_rank_ff;
	reg        any_data_ff;
	reg        in_sr_ff;
	wire       is_pre  = (cmd_issue == `DCTG_CMD_PRE);
	wire       is_act  = (cmd_issue == `DCTG_CMD_ACT);
	wire       is_rd   = (cmd_issue == `DCTG_CMD_RD);
	wire       is_rfm  = (cmd_issue == `DCTG_CMD_REF) || (cmd_issue == `DCTG_CMD_MRS);
	wire       is_zq   = (cmd_issue == `DCTG_CMD_ZQCS);
	wire       cke_go  = (cke_request != cke_ff);
	wire       pd_exit = cke_go && cke_request && !in_sr_ff;
	wire       sr_exit = cke_go && cke_request && in_sr_ff;
	wire       rank_sw = (rd_data_start || wr_data_start) && any_data_ff &&
		(data_rank != last_rank_ff) && (wr_data_start == last_dir_wr_ff);

	wire b_rp, b_rcd, b_xp, b_xsnr, b_xsrd, b_rtp, b_cke, b_csta, b_ckesr, b_zq, b_rfc, b_rtw;

	// ****************************************
	// Hold-off counters
	// ****************************************
	// One counter per constraint, reloaded by its trigger [RULE_16]
	dctg_counter #(.WIDTH(5)) u_rp (.mclk(mclk), .resetn(resetn),
		.load(is_pre), .value(precharge_period), .busy(b_rp)); // [RULE_02]
	dctg_counter #(.WIDTH(5)) u_rcd (.mclk(mclk), .resetn(resetn),
		.load(is_act), .value(row_to_column_delay), .busy(b_rcd)); // [RULE_03]
	dctg_counter #(.WIDTH(4)) u_xp (.mclk(mclk), .resetn(resetn),
		.load(pd_exit), .value(powerdown_exit_delay), .busy(b_xp)); // [RULE_04]
	dctg_counter #(.WIDTH(10)) u_xsnr (.mclk(mclk), .resetn(resetn),
		.load(sr_exit), .value(selfrefresh_exit_nodll), .busy(b_xsnr)); // [RULE_05]
	dctg_counter #(.WIDTH(10)) u_xsrd (.mclk(mclk), .resetn(resetn),
		.load(sr_exit), .value(selfrefresh_exit_dll), .busy(b_xsrd)); // [RULE_06]
	// Single counter, not per bank: conservative across banks
	dctg_counter #(.WIDTH(4)) u_rtp (.mclk(mclk), .resetn(resetn),
		.load(is_rd), .value(read_to_precharge), .busy(b_rtp)); // [RULE_07]
	dctg_counter #(.WIDTH(4)) u_cke (.mclk(mclk), .resetn(resetn),
		.load(cke_go && !b_cke), .value(cke_min_hold), .busy(b_cke)); // [RULE_08]
	dctg_counter #(.WIDTH(4)) u_csta (.mclk(mclk), .resetn(resetn),
		.load(rd_data_start || wr_data_start), .value(rank_switch_gap),
		.busy(b_csta)); // [RULE_09]
	dctg_counter #(.WIDTH(4)) u_ckesr (.mclk(mclk), .resetn(resetn),
		.load(selfrefresh_entered), .value(selfrefresh_min_residency),
		.busy(b_ckesr)); // [RULE_10]
	dctg_counter #(.WIDTH(8)) u_zq (.mclk(mclk), .resetn(resetn),
		.load(is_zq), .value(short_calibration_time), .busy(b_zq)); // [RULE_11]
	dctg_counter #(.WIDTH(10)) u_rfc (.mclk(mclk), .resetn(resetn),
		.load(is_rfm), .value(refresh_cycle_time), .busy(b_rfc)); // [RULE_12]
	dctg_counter #(.WIDTH(3)) u_rtw (.mclk(mclk), .resetn(resetn),
		.load(rd_data_start), .value(read_write_turnaround), .busy(b_rtw)); // [RULE_01]

	// ****************************************
	// Clock enable and data-phase history
	// ****************************************
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cke_ff         <= 1'b0;
			in_sr_ff       <= 1'b0;
			last_dir_wr_ff <= 1'b0;
			last_rank_ff   <= 1'b0;
			any_data_ff    <= 1'b0;
		end else begin
			// Request ignored while the hold is running
			if (cke_go && !b_cke)
				cke_ff <= cke_request; // [RULE_08]
			// Entry wins over exit in the same cycle
			if (selfrefresh_entered)
				in_sr_ff <= 1'b1;
			else if (sr_exit && !b_cke)
				in_sr_ff <= 1'b0;
			if (rd_data_start || wr_data_start) begin
				last_dir_wr_ff <= wr_data_start;
				last_rank_ff   <= data_rank;
				any_data_ff    <= 1'b1;
			end
		end
	end

	// ****************************************
	// Permissions to the scheduler
	// ****************************************
	wire exit_wait = b_xp || b_xsnr;
	assign memory_clock_enable_out = cke_ff;
	assign allow_act_ref = !b_rp && !b_rfc && !b_zq && !exit_wait; // [RULE_02] [RULE_12]
	assign allow_rd_wr   = !b_rcd && !b_zq && !b_xsnr; // [RULE_03]
	assign allow_pre     = !b_rtp && !b_zq && !exit_wait; // [RULE_07]
	assign allow_other   = !b_zq && !exit_wait; // [RULE_04] [RULE_05] [RULE_11]
	assign allow_dll_cmd = !b_xsrd && !b_zq && !b_xsnr; // [RULE_06]
	assign allow_rd_data = !(b_csta && !last_dir_wr_ff && any_data_ff); // [RULE_09]
	assign allow_wr_data = !b_rtw && !(b_csta && last_dir_wr_ff); // [RULE_01] [RULE_09]
	assign allow_sr_exit = in_sr_ff && !b_ckesr && !b_cke; // [RULE_10]

	assign status_word = {16'h0000, rank_sw, allow_sr_exit, in_sr_ff, cke_ff, b_rtw,
		b_rfc, b_zq, b_ckesr, b_csta, b_cke, b_rtp, b_xsrd, b_xsnr, b_xp, b_rcd, b_rp};
endmodule

// ===== dctg_guard_asserts.sv
// Checker for the DDR3 command timing guard, bound to its top ports.
// Assumes one clock, mclk, and the asynchronous active-low resetn.
`include "dctg_defines.vh"

module dctg_guard_chk (
	// Clock and reset
	input wire       mclk,
	input wire       resetn,
	// Register bus
	input wire       s_axi_arvalid,
	input wire       s_axi_arready,
	input wire       s_axi_rvalid,
	input wire       s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire       s_axi_bvalid,
	input wire       s_axi_bready,
	input wire [1:0] s_axi_bresp,
	// Scheduler side
	input wire [2:0] cmd_issue,
	input wire       rd_data_start,
	input wire       wr_data_start,
	input wire       selfrefresh_entered,
	input wire       allow_act_ref,
	input wire       allow_rd_wr,
	input wire       allow_pre,
	input wire       allow_other,
	input wire       allow_wr_data,
	input wire       allow_sr_exit,
	input wire       memory_clock_enable_out
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	// ****************************************
	// Hold-off after command and data triggers, and AXI4-Lite answer holds
	// ****************************************
	pre_holds_act_a: assert property (cmd_issue == `DCTG_CMD_PRE |=> !allow_act_ref)
		else $error("activate allowed right after precharge");
	act_holds_col_a: assert property (cmd_issue == `DCTG_CMD_ACT |=> !allow_rd_wr)
		else $error("column command allowed right after activate");
	read_holds_pre_a: assert property (cmd_issue == `DCTG_CMD_RD |=> !allow_pre)
		else $error("precharge allowed right after read");
	refresh_holds_a: assert property ((cmd_issue == `DCTG_CMD_REF ||
		cmd_issue == `DCTG_CMD_MRS) |=> !allow_act_ref)
		else $error("activate allowed right after refresh or mode load");
	zq_holds_cmd_a: assert property (cmd_issue == `DCTG_CMD_ZQCS |=> !allow_other)
		else $error("command allowed right after short calibration");
	turnaround_gap_a: assert property (rd_data_start |=> !allow_wr_data)
		else $error("write data allowed right after read data");
	rank_gap_a: assert property (wr_data_start |=> !allow_wr_data)
		else $error("write data allowed right after write data");
	sr_residency_a: assert property (selfrefresh_entered |=> !allow_sr_exit)
		else $error("self-refresh exit allowed right after entry");
	cke_hold_a: assert property ($changed(memory_clock_enable_out) |=>
		$stable(memory_clock_enable_out))
		else $error("clock enable toggled twice in a row");
	exit_holds_a: assert property ($rose(memory_clock_enable_out) |-> !allow_other)
		else $error("command allowed on the cycle of power-down exit");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	read_stands_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	bresp_stands_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");

	pre_seen_c: cover property (cmd_issue == `DCTG_CMD_PRE ##1 !allow_act_ref);
	sr_seen_c: cover property (selfrefresh_entered ##1 !allow_sr_exit);
	cke_fall_c: cover property ($fell(memory_clock_enable_out));
endmodule

// ===== dctg_guard_tb.sv
// Bench for the DDR3 command timing guard: AXI4-Lite register access
// and timed hold-off checks. Assumes a single 25 MHz clock.
`include "dctg_defines.vh"

module dctg_guard_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// Small field values keep every hold-off short
	localparam int RTW = 2, RP = 3, RCD = 1, XP = 2, XSNR = 5, XSRD = 9, RTP = 1, CKEH = 4;
	localparam int CSTA = 3, CKESR = 4, ZQ = 6, RFC = 7;
	localparam logic [31:0] RST_V [3] = '{32'h0000_1FFF, 32'hFFFF_FFFF, 32'hFFFF_3FFF};
	localparam logic [31:0] PRG_V [3] = '{
		32'(RTW << `DCTG_RTW_LSB | RP << `DCTG_RP_LSB | RCD),
		32'(XP << `DCTG_XP_LSB | XSNR << `DCTG_XSNR_LSB | XSRD << `DCTG_XSRD_LSB
			| RTP << `DCTG_RTP_LSB | CKEH),
		32'(CSTA << `DCTG_CSTA_LSB | CKESR << `DCTG_CKESR_LSB | ZQ << `DCTG_ZQCS_LSB
			| RFC << `DCTG_RFC_LSB | 15)};
	logic        mclk, resetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  r;
	logic [2:0]  cmd_issue;
	logic        cmd_rank, rd_data_start, wr_data_start, data_rank, cke_request, sr_entered;
	wire         awready, wready, bvalid, arready, rvalid, cke;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [7:0]  allows;
	wire  [15:0] last_run;
	int          n_fail, n_compared, cnt [8], i;

	dctg_guard dut_u (.mclk(mclk), .resetn(resetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .cmd_issue(cmd_issue), .cmd_rank(cmd_rank),
		.rd_data_start(rd_data_start), .wr_data_start(wr_data_start),
		.data_rank(data_rank), .cke_request(cke_request),
		.selfrefresh_entered(sr_entered), .allow_act_ref(allows[0]),
		.allow_rd_wr(allows[1]), .allow_pre(allows[2]), .allow_other(allows[3]),
		.allow_dll_cmd(allows[4]), .allow_rd_data(allows[5]), .allow_wr_data(allows[6]),
		.allow_sr_exit(allows[7]), .memory_clock_enable_out(cke));
	dctg_sdram_model mem_u (.mclk(mclk), .resetn(resetn), .cke(cke), .last_run(last_run));

	task chk(input [31:0] g, input [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	task results;
		if (n_fail == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task axi_wr(input [7:0] a, input [31:0] v, output [1:0] rs);
		bit done;
		begin
			done = 0;
			@(posedge mclk);
			awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
			for (int t = 0; t < 100 && !done; t++) begin
				@(posedge mclk);
				if (awvalid && awready) awvalid <= 1'b0;
				if (wvalid && wready) wvalid <= 1'b0;
				if (bvalid === 1'b1) begin
					rs = bresp; bready <= 1'b0; done = 1;
				end
			end
			chk(32'(done), 32'h0000_0001);
		end
	endtask

	task axi_rd(input [7:0] a, output [31:0] v, output [1:0] rs);
		bit done;
		begin
			done = 0;
			@(posedge mclk);
			araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
			for (int t = 0; t < 100 && !done; t++) begin
				@(posedge mclk);
				if (arvalid && arready) arvalid <= 1'b0;
				if (rvalid === 1'b1) begin
					v = rdata; rs = rresp; rready <= 1'b0; done = 1;
				end
			end
			chk(32'(done), 32'h0000_0001);
		end
	endtask

	// Pulse a trigger, then count cycles each permission stays low
	task fire(input [2:0] c, input [3:0] p, input k, input int idx, input int ex);
		begin
			@(posedge mclk);
			cmd_issue <= c; cmd_rank <= p[3]; cke_request <= k;
			{data_rank, sr_entered, wr_data_start, rd_data_start} <= p;
			@(posedge mclk);
			cmd_issue <= `DCTG_CMD_NOP;
			{sr_entered, wr_data_start, rd_data_start} <= 3'h0;
			#1;
			cnt = '{default: 0};
			for (int t = 0; t < 2000 && allows[idx] !== 1'b1; t++) begin
				for (int j = 0; j < 8; j++) if (allows[j] !== 1'b1) cnt[j]++;
				@(posedge mclk);
				#1;
			end
			chk(32'(cnt[idx]), 32'(ex));
		end
	endtask

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Whole run is under two hundred cycles
	initial begin
		#(40 * 5000);
		n_fail++;
		$display("[ERR] %0t watchdog expired", $time);
		results;
	end

	initial begin
		resetn = 1'b0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
		awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000; wstrb = 4'hF;
		cmd_issue = `DCTG_CMD_NOP; cmd_rank = 0; rd_data_start = 0; wr_data_start = 0;
		data_rank = 0; cke_request = 0; sr_entered = 0;
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		for (i = 0; i < 3; i++) begin
			axi_rd(8'(4 * i), d, r);
			chk(d, RST_V[i]);
			axi_wr(8'(4 * i), 32'hFFFF_FFFF, r);
			axi_rd(8'(4 * i), d, r);
			chk(d, RST_V[i]);
			axi_wr(8'(4 * i), PRG_V[i], r);
			chk(32'(r), 32'h0000_0000);
			axi_rd(8'(4 * i), d, r);
			chk(d, PRG_V[i]);
		end
		axi_wr(8'h10, 32'h1234_5678, r);
		chk(32'(r), 32'h0000_0003);
		axi_rd(8'h10, d, r);
		chk({d[29:0], r}, 32'h0000_0003);
		fire(`DCTG_CMD_PRE, 4'h0, 1'b0, 0, RP + 1);
		fire(`DCTG_CMD_ACT, 4'h0, 1'b0, 1, RCD + 1);
		fire(`DCTG_CMD_RD, 4'h0, 1'b0, 2, RTP + 1);
		fire(`DCTG_CMD_REF, 4'h0, 1'b0, 0, RFC + 1);
		fire(`DCTG_CMD_MRS, 4'h0, 1'b0, 0, RFC + 1);
		fire(`DCTG_CMD_ZQCS, 4'h0, 1'b0, 3, ZQ + 1);
		fire(`DCTG_CMD_NOP, 4'h1, 1'b0, 6, RTW + 1);
		fire(`DCTG_CMD_NOP, 4'hA, 1'b0, 6, CSTA + 1);
		fire(`DCTG_CMD_NOP, 4'h9, 1'b0, 5, CSTA + 1);
		fire(`DCTG_CMD_NOP, 4'h0, 1'b1, 3, XP + 1);
		chk(32'(cke), 32'h0000_0001);
		@(posedge mclk);
		cke_request <= 1'b0;
		for (int t = 0; t < 100 && cke !== 1'b0; t++) @(posedge mclk);
		repeat (2) @(posedge mclk);
		// Hold runs N+1 cycles after the change edge; next change lands one edge later
		chk(32'(last_run), 32'(CKEH + 2));
		fire(`DCTG_CMD_NOP, 4'h4, 1'b0, 7, CKESR + 1);
		fire(`DCTG_CMD_NOP, 4'h0, 1'b1, 4, XSRD + 1);
		chk(32'(cnt[3]), 32'(XSNR + 1));
		// All holds idle, clock enable high, out of self-refresh
		axi_rd(`DCTG_OFS_GUARD_STATUS, d, r);
		chk(d, 32'h0000_1000);
		// Reset in mid-run: permissions, pin and the power-exit register back to defaults
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(32'({cke, allows}), 32'h0000_007F);
		resetn <= 1'b1;
		axi_rd(`DCTG_OFS_POWER_EXIT_TIMING, d, r);
		chk(d, RST_V[1]);
		results;
	end
endmodule

bind dctg_guard dctg_guard_chk chk_u (.mclk(mclk), .resetn(resetn),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.cmd_issue(cmd_issue), .rd_data_start(rd_data_start), .wr_data_start(wr_data_start),
	.selfrefresh_entered(selfrefresh_entered), .allow_act_ref(allow_act_ref),
	.allow_rd_wr(allow_rd_wr), .allow_pre(allow_pre), .allow_other(allow_other),
	.allow_wr_data(allow_wr_data), .allow_sr_exit(allow_sr_exit),
	.memory_clock_enable_out(memory_clock_enable_out));

// ===== dctg_sdram_model.sv
// Memory-side watcher: measures how long the clock enable pin rests.
// Assumes it sees the pin on the same clock as the guard.
module dctg_sdram_model (
	// Clock and reset
	input wire        mclk,
	input wire        resetn,
	// Memory pin
	input wire        cke,
	// Observation
	output logic [15:0] last_run
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        prev_cke_ff;
	logic [15:0] run_ff;

	// Length of the finished level, in edges, kept for the bench
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			prev_cke_ff <= 1'b0;
			run_ff      <= 16'h0000;
			last_run    <= 16'h0000;
		end else if (cke !== prev_cke_ff) begin
			last_run    <= run_ff;
			run_ff      <= 16'h0001;
			prev_cke_ff <= cke;
		end else begin
			run_ff <= run_ff + 16'h0001;
		end
	end
endmodule
